/* File: rtl/sfc_pkg.sv */
// Package: constants and types for the serial flash command host
package sfc_pkg;
    localparam int INSTR_BITS   = 8;
    localparam int ADDR_BITS    = 32;
    localparam int DATA_BITS    = 8;
    localparam int LEN_W        = 6;
    localparam int DUMMY_W      = 5;
    localparam int CLK_HZ       = 25000000;
    localparam int SCK_HALF_NS  = 80;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam logic [1:0] WIDTH_X1 = 2'h0;
    localparam logic [1:0] WIDTH_X2 = 2'h1;
    localparam logic [1:0] WIDTH_X4 = 2'h2;

    typedef enum logic [1:0] {
        SFC_MODE0,
        SFC_MODE3
    } sfc_clkmode_e;

    typedef enum logic [2:0] {
        SFC_IDLE,
        SFC_INSTR,
        SFC_ADDR,
        SFC_MODEB,
        SFC_DUMMY,
        SFC_WRITE,
        SFC_READ,
        SFC_END
    } sfc_state_e;
endpackage : sfc_pkg

/* File: rtl/sfc_clkdiv.sv */
// SCK edge-enable generator for the command host
`timescale 1ns/100ps
`default_nettype none
module sfc_clkdiv (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      tick
);
    logic [7:0] cnt;
    wire        wrap = (cnt == 8'(sfc_pkg::SCK_HALF_CYC - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
        end else if (!run || wrap) begin
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

    assign tick = run && wrap;
endmodule : sfc_clkdiv
`default_nettype wire

/* File: rtl/sfc_host.sv */
// Host controller that issues commands to a multi-lane serial flash
// How it works
// - SCK idles per mode 0 or 3 only
// - Host idles SCK low (mode 0) or high (mode 3)
// - Cycles counted falling to falling SCK edge
// - Mode 0 first cycle starts at select fall
// - DDR works in both modes, same counting
// - First DDR address bit on next rising edge
// - Each command opens with 8-bit instruction unless CMD_SKIP_INSTR is set
// - Then optional address, mode and dummy (only after an address), data
// - 1-1-1 uses lane zero out, lane one in
// - 1-1-2/1-1-4 serial address, wide read data
// - 1-2-2/1-4-4 wide address, mode and data
// - All-quad mode sends everything four wide
// - Select low for whole command, high ends it
// - MSB first, low bit on lane zero
`timescale 1ns/100ps
`default_nettype none
module sfc_host (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        NRST,
    // Command request
    input  wire logic        CMD_VALID,
    output logic             CMD_READY,
    input  wire logic        CMD_MODE3,
    input  wire logic        CMD_DDR,
    input  wire logic        CMD_SKIP_INSTR,
    input  wire logic [7:0]  CMD_INSTR,
    input  wire logic [1:0]  CMD_INSTR_W,
    input  wire logic [5:0]  CMD_ADDR_BITS,
    input  wire logic [31:0] CMD_ADDR,
    input  wire logic [1:0]  CMD_ADDR_W,
    input  wire logic        CMD_HAS_MODE,
    input  wire logic [7:0]  CMD_MODE_BITS,
    input  wire logic [4:0]  CMD_DUMMY,
    input  wire logic [1:0]  CMD_DATA_W,
    input  wire logic        CMD_WRITE,
    input  wire logic [5:0]  CMD_NBYTES,
    // Write data stream
    input  wire logic [7:0]  WR_DATA,
    output logic             WR_TAKE,
    // Read data stream
    output logic [7:0]       RD_DATA,
    output logic             RD_VALID,
    output logic             BUSY,
    // Flash pins
    output logic             CS_N,
    output logic             SCK,
    input  wire logic [3:0]  LANE_IN,
    output logic [3:0]       LANE_OUT,
    output logic [3:0]       LANE_OE
);
    logic                rst_s1;
    logic                rst_n;
    logic [3:0]          lane_s1;
    logic [3:0]          lane_s2;
    sfc_pkg::sfc_state_e state;
    sfc_pkg::sfc_state_e next_state;
    logic                mode3;
    logic                ddr;
    logic [1:0]          addr_w;
    logic [1:0]          data_w;
    logic                wr;
    logic [5:0]          addr_bits;
    logic [4:0]          dummy;
    logic [5:0]          nbytes;
    logic                has_mode;
    logic [31:0]         sh;
    logic [5:0]          left;
    logic [7:0]          rx;
    logic [3:0]          rx_cnt;
    logic                sck_q;
    logic                tick;
    logic                half;
    logic                lead;
    logic                rd_lag;

    // Reset release through two flops
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // Input lanes pass two flops
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            lane_s1 <= 4'h0;
            lane_s2 <= 4'h0;
        end else begin
            lane_s1 <= LANE_IN;
            lane_s2 <= lane_s1;
        end
    end

    function automatic logic [5:0] lane_step(input logic [1:0] w);
        lane_step = (w == sfc_pkg::WIDTH_X4) ? 6'h04 :
                    (w == sfc_pkg::WIDTH_X2) ? 6'h02 : 6'h01;
    endfunction : lane_step

    wire running = (state != sfc_pkg::SFC_IDLE) && (state != sfc_pkg::SFC_END);

    sfc_clkdiv u_div (
        .clk  (CLK),
        .rst_n(rst_n),
        .run  (running || state == sfc_pkg::SFC_END),
        .tick (tick)
    );

    // half=0: next tick is a falling edge (launch); half=1: rising edge (sample)
    wire fall_tick = tick && !half;
    wire rise_tick = tick && half;
    wire ddr_phase = ddr && (state != sfc_pkg::SFC_INSTR);
    // DDR shifts on every edge after the instruction; SDR shifts on falls only
    // Mode 3 lead-in fall only leaves the idle level and carries no bit
    wire shift_now = !lead && (ddr_phase ? tick : fall_tick);
    // Synced lanes trail the device by more than half an SCK period: take late
    wire samp_now  = ddr_phase ? (tick && rd_lag) : fall_tick;

    wire [1:0] cur_w = (state == sfc_pkg::SFC_INSTR) ? addr_w :
                       (state == sfc_pkg::SFC_ADDR || state == sfc_pkg::SFC_MODEB) ? addr_w :
                       data_w;
    wire [5:0] step  = lane_step(cur_w);
    wire       last  = (left <= step);

    // Outgoing group: top bits of shifter, low bit on lane zero
    wire [3:0] tx_grp = (cur_w == sfc_pkg::WIDTH_X4) ? sh[31:28] :
                        (cur_w == sfc_pkg::WIDTH_X2) ? {2'h0, sh[31:30]} :
                        {3'h0, sh[31]};
    wire [3:0] rx_grp = (data_w == sfc_pkg::WIDTH_X4) ? lane_s2 :
                        (data_w == sfc_pkg::WIDTH_X2) ? {2'h0, lane_s2[1:0]} :
                        {3'h0, lane_s2[1]};
    wire [7:0] rx_nxt = (data_w == sfc_pkg::WIDTH_X4) ? {rx[3:0], lane_s2} :
                        (data_w == sfc_pkg::WIDTH_X2) ? {rx[5:0], rx_grp[1:0]} :
                        {rx[6:0], rx_grp[0]};

    wire drive_ph = (state == sfc_pkg::SFC_INSTR) || (state == sfc_pkg::SFC_ADDR) ||
                    (state == sfc_pkg::SFC_MODEB) || (state == sfc_pkg::SFC_WRITE);
    wire [3:0] oe_mask = (cur_w == sfc_pkg::WIDTH_X4) ? 4'hF :
                         (cur_w == sfc_pkg::WIDTH_X2) ? 4'h3 : 4'h1;

    // Phase sequencing after an element finishes
    always_comb begin
        next_state = state;
        unique case (state)
            sfc_pkg::SFC_IDLE:  next_state = state;
            sfc_pkg::SFC_INSTR:
                next_state = (addr_bits != 6'h00) ? sfc_pkg::SFC_ADDR :
                             (nbytes == 6'h00) ? sfc_pkg::SFC_END :
                             wr ? sfc_pkg::SFC_WRITE : sfc_pkg::SFC_READ;
            sfc_pkg::SFC_ADDR:
                next_state = has_mode ? sfc_pkg::SFC_MODEB :
                             (dummy != 5'h00) ? sfc_pkg::SFC_DUMMY :
                             (nbytes == 6'h00) ? sfc_pkg::SFC_END :
                             wr ? sfc_pkg::SFC_WRITE : sfc_pkg::SFC_READ;
            sfc_pkg::SFC_MODEB:
                next_state = (dummy != 5'h00) ? sfc_pkg::SFC_DUMMY :
                             (nbytes == 6'h00) ? sfc_pkg::SFC_END :
                             wr ? sfc_pkg::SFC_WRITE : sfc_pkg::SFC_READ;
            sfc_pkg::SFC_DUMMY:
                next_state = (nbytes == 6'h00) ? sfc_pkg::SFC_END :
                             wr ? sfc_pkg::SFC_WRITE : sfc_pkg::SFC_READ;
            sfc_pkg::SFC_WRITE: next_state = sfc_pkg::SFC_END;
            sfc_pkg::SFC_READ:  next_state = sfc_pkg::SFC_END;
            sfc_pkg::SFC_END:   next_state = sfc_pkg::SFC_IDLE;
        endcase
    end

    wire start = (state == sfc_pkg::SFC_IDLE) && CMD_VALID;
    wire [1:0] iw = CMD_INSTR_W;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state     <= sfc_pkg::SFC_IDLE;
            mode3     <= 1'b0;
            ddr       <= 1'b0;
            addr_w    <= sfc_pkg::WIDTH_X1;
            data_w    <= sfc_pkg::WIDTH_X1;
            wr        <= 1'b0;
            addr_bits <= 6'h00;
            dummy     <= 5'h00;
            nbytes    <= 6'h00;
            has_mode  <= 1'b0;
            sh        <= 32'h0000_0000;
            left      <= 6'h00;
            half      <= 1'b0;
            lead      <= 1'b0;
            rd_lag    <= 1'b0;
            sck_q     <= 1'b0;
            rx        <= 8'h00;
            rx_cnt    <= 4'h0;
            RD_DATA   <= 8'h00;
            RD_VALID  <= 1'b0;
            CS_N      <= 1'b1;
        end else begin
            RD_VALID <= 1'b0;
            if (start) begin
                mode3     <= CMD_MODE3;
                sck_q     <= CMD_MODE3;
                ddr       <= CMD_DDR;
                addr_w    <= CMD_ADDR_W;
                data_w    <= CMD_DATA_W;
                wr        <= CMD_WRITE;
                addr_bits <= CMD_ADDR_BITS;
                dummy     <= CMD_DUMMY;
                nbytes    <= CMD_NBYTES;
                has_mode  <= CMD_HAS_MODE;
                CS_N      <= 1'b0;
                // Mode 3: first tick falls SCK; mode 0: SCK already low, so first tick rises
                half      <= !CMD_MODE3;
                lead      <= CMD_MODE3;
                rx_cnt    <= 4'h0;
                if (CMD_SKIP_INSTR) begin
                    state <= (CMD_ADDR_BITS != 6'h00) ? sfc_pkg::SFC_ADDR : sfc_pkg::SFC_END;
                    sh    <= CMD_ADDR << (6'd32 - CMD_ADDR_BITS);
                    left  <= CMD_ADDR_BITS;
                end else begin
                    state <= sfc_pkg::SFC_INSTR;
                    sh    <= {CMD_INSTR, 24'h000000};
                    left  <= 6'(sfc_pkg::INSTR_BITS);
                    addr_w <= iw;
                end
            end else if (tick && running) begin
                sck_q <= !sck_q;
                half  <= !half;
                lead  <= 1'b0;
                rd_lag <= (state == sfc_pkg::SFC_READ);
                if (shift_now && state != sfc_pkg::SFC_READ) begin
                    if (state == sfc_pkg::SFC_DUMMY) begin
                        // One dummy cycle per falling edge
                        // Latency always closes on a falling edge, DDR too
                        if (fall_tick && (dummy == 5'h01 || dummy == 5'h00)) begin
                            state <= next_state;
                            left  <= 6'h08;
                            sh    <= {WR_DATA, 24'h000000};
                        end
                        if (fall_tick) begin
                            dummy <= dummy - 5'h01;
                        end
                    end else if (last) begin
                        state <= next_state;
                        if (state == sfc_pkg::SFC_INSTR) begin
                            addr_w <= CMD_ADDR_W;
                            // No address: data follows the instruction directly
                            sh     <= (addr_bits != 6'h00) ?
                                      CMD_ADDR << (6'd32 - addr_bits) :
                                      {WR_DATA, 24'h000000};
                            left   <= (addr_bits != 6'h00) ? addr_bits : 6'h08;
                        end else if (state == sfc_pkg::SFC_ADDR) begin
                            sh   <= {CMD_MODE_BITS, 24'h000000};
                            left <= has_mode ? 6'h08 : 6'h08;
                            if (!has_mode) begin
                                sh <= {WR_DATA, 24'h000000};
                            end
                        end else if (state == sfc_pkg::SFC_WRITE &&
                                     nbytes != 6'h01) begin
                            state  <= sfc_pkg::SFC_WRITE;
                            nbytes <= nbytes - 6'h01;
                            sh     <= {WR_DATA, 24'h000000};
                            left   <= 6'h08;
                        end else begin
                            sh   <= {WR_DATA, 24'h000000};
                            left <= 6'h08;
                        end
                    end else begin
                        sh   <= sh << step;
                        left <= left - step;
                    end
                end
                if (samp_now && state == sfc_pkg::SFC_READ) begin
                    rx     <= rx_nxt;
                    rx_cnt <= 4'(rx_cnt + step[3:0]);
                    if (4'(rx_cnt + step[3:0]) == 4'h8) begin
                        RD_DATA  <= rx_nxt;
                        RD_VALID <= 1'b1;
                        rx_cnt   <= 4'h0;
                        nbytes   <= nbytes - 6'h01;
                        if (nbytes == 6'h01) begin
                            state <= sfc_pkg::SFC_END;
                        end
                    end
                end
            end else if (tick && state == sfc_pkg::SFC_END) begin
                sck_q <= mode3;
                CS_N  <= 1'b1;
                state <= sfc_pkg::SFC_IDLE;
            end
        end
    end

    // Write byte consumed when its last group leaves in the write phase
    assign WR_TAKE   = (state == sfc_pkg::SFC_WRITE) && shift_now && last && tick;
    assign CMD_READY = (state == sfc_pkg::SFC_IDLE);
    assign BUSY      = !CMD_READY;
    assign SCK       = sck_q;
    assign LANE_OUT  = drive_ph ? tx_grp : 4'h0;
    assign LANE_OE   = drive_ph ? oe_mask : 4'h0;
endmodule : sfc_host
`default_nettype wire

/* File: bench/sfc_host_chk.sv */
// Pin-level assertions for the command host
`timescale 1ns/100ps
`default_nettype none
module sfc_host_chk (
    // Watched pins
    input wire logic       CLK,
    input wire logic       NRST,
    input wire logic       CMD_VALID,
    input wire logic       CMD_READY,
    input wire logic       CMD_MODE3,
    input wire logic       RD_VALID,
    input wire logic       BUSY,
    input wire logic       CS_N,
    input wire logic       SCK,
    input wire logic [3:0] LANE_OE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    property p_take; CMD_VALID && CMD_READY |=> !CS_N && BUSY; endproperty
    a_take: assert property (p_take) else $error("select not asserted after take");
    property p_sel; !CS_N |-> BUSY; endproperty
    a_sel: assert property (p_sel) else $error("selected while not busy");
    property p_first; CMD_VALID && CMD_READY |=> SCK == $past(CMD_MODE3); endproperty
    a_first: assert property (p_first) else $error("clock level wrong at select");
    property p_end; $rose(CS_N) |-> SCK == CMD_MODE3; endproperty
    a_end: assert property (p_end) else $error("clock not idle at deselect");
    property p_quiet; CS_N && $past(CS_N) |-> $stable(SCK); endproperty
    a_quiet: assert property (p_quiet) else $error("clock moved while deselected");
    property p_oe; CS_N |-> LANE_OE == 4'h0; endproperty
    a_oe: assert property (p_oe) else $error("lane driven while deselected");
    property p_half; !CS_N && $changed(SCK) |=> $stable(SCK); endproperty
    a_half: assert property (p_half) else $error("clock half period too short");
    property p_min; $fell(CS_N) |-> !CS_N [*4]; endproperty
    a_min: assert property (p_min) else $error("select too short");
    property p_rdv; RD_VALID |=> !RD_VALID; endproperty
    a_rdv: assert property (p_rdv) else $error("read strobe too long");
    c_rd3: cover property (RD_VALID && CMD_MODE3);
    c_end3: cover property ($rose(CS_N) && CMD_MODE3);
    c_take0: cover property (CMD_VALID && CMD_READY && !CMD_MODE3);
endmodule : sfc_host_chk
bind sfc_host sfc_host_chk sfc_host_chk_inst (.CLK(CLK), .NRST(NRST), .CMD_VALID(CMD_VALID),
    .CMD_READY(CMD_READY), .CMD_MODE3(CMD_MODE3), .RD_VALID(RD_VALID), .BUSY(BUSY),
    .CS_N(CS_N), .SCK(SCK), .LANE_OE(LANE_OE));
`default_nettype wire

/* File: bench/sfc_flash_model.sv */
// Behavioural flash pin model: logs host groups, returns a byte ramp
`timescale 1ns/100ps
`default_nettype none
module sfc_flash_model (
    // Host pins
    input wire logic       clk,
    input wire logic       cs_n,
    input wire logic       sck,
    input wire logic [3:0] lane_out,
    input wire logic [3:0] lane_oe,
    // Command shape
    input wire logic       ddr,
    input wire logic [7:0] ddr_fall,
    input wire logic [7:0] rd_fall,
    input wire logic [2:0] rd_w,
    input wire logic [7:0] rd_base,
    // Device drive
    output logic [3:0]     dev_out,
    output logic [3:0]     dev_oe
);
    logic [3:0] rx[$];
    logic       sck_q, cs_q;
    logic [3:0] lane_q, oe_q;
    int         falls, bitp;
    function automatic logic [3:0] grp(input int p);
        logic [7:0] b;
        int         k;
        grp = 4'h0;
        for (int j = 0; j < int'(rd_w); j++) begin
            k = p + int'(rd_w) - 1 - j;
            b = rd_base + 8'(k / 8);
            grp[j] = b[7 - k % 8];
        end
        if (rd_w == 3'h1) grp = grp << 1;
    endfunction : grp
    initial dev_oe = 4'h0;
    // Values just before each clock edge are what the device latches
    always @(posedge clk) begin
        sck_q <= sck;
        cs_q <= cs_n;
        lane_q <= lane_out;
        oe_q <= lane_oe;
        if (cs_n || cs_q) begin
            falls <= 0;
            bitp <= 0;
            dev_oe <= 4'h0;
        end else if (sck != sck_q) begin
            if (!sck) falls <= falls + 1;
            if (oe_q != 4'h0 && (sck || (ddr && falls >= int'(ddr_fall)))) rx.push_back(lane_q);
            if ((!sck && falls + 1 >= int'(rd_fall)) || (ddr && sck && dev_oe != 4'h0)) begin
                dev_out <= grp(bitp);
                dev_oe <= (rd_w == 3'h1) ? 4'h2 : 4'((1 << rd_w) - 1);
                bitp <= bitp + int'(rd_w);
            end
        end
    end
endmodule : sfc_flash_model
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the serial flash command host
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        clk, nrst, cmd_valid, cmd_ready, m3, ddr, skip, hm, wr, wr_take;
    logic        rd_valid, busy, cs_n, sck;
    logic [7:0]  instr, mbits, wr_data, rd_data, rd_base, ddr_fall, rd_fall;
    logic [1:0]  iw, aw, dw;
    logic [5:0]  ab, nb;
    logic [4:0]  dm;
    logic [31:0] addr;
    logic [3:0]  lane_in, lane_out, lane_oe, dev_out, dev_oe, last;
    logic [2:0]  rd_w;
    logic [7:0]  wq[$], got[$];
    logic [3:0]  exq[$], emk[$];
    int          error_cnt, checked, seed;
    sfc_host sfc_host_inst (.CLK(clk), .NRST(nrst), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
        .CMD_MODE3(m3), .CMD_DDR(ddr), .CMD_SKIP_INSTR(skip), .CMD_INSTR(instr),
        .CMD_INSTR_W(iw), .CMD_ADDR_BITS(ab), .CMD_ADDR(addr), .CMD_ADDR_W(aw),
        .CMD_HAS_MODE(hm), .CMD_MODE_BITS(mbits), .CMD_DUMMY(dm), .CMD_DATA_W(dw),
        .CMD_WRITE(wr), .CMD_NBYTES(nb), .WR_DATA(wr_data), .WR_TAKE(wr_take),
        .RD_DATA(rd_data), .RD_VALID(rd_valid), .BUSY(busy), .CS_N(cs_n), .SCK(sck),
        .LANE_IN(lane_in), .LANE_OUT(lane_out), .LANE_OE(lane_oe));
    sfc_flash_model sfc_flash_model_inst (.clk(clk), .cs_n(cs_n), .sck(sck),
        .lane_out(lane_out), .lane_oe(lane_oe), .ddr(ddr), .ddr_fall(ddr_fall),
        .rd_fall(rd_fall), .rd_w(rd_w), .rd_base(rd_base), .dev_out(dev_out), .dev_oe(dev_oe));
    // Undriven lanes flip every cycle so a stale value never reads as data
    assign lane_in = (dev_oe & dev_out) | (~dev_oe & lane_oe & lane_out)
                   | (~dev_oe & ~lane_oe & ~last);
    always @(posedge clk) last <= lane_in;
    always @(negedge clk) begin
        if (wr_take === 1'b1 && wq.size() > 0) void'(wq.pop_front());
        wr_data <= (wq.size() > 0) ? wq[0] : 8'($random(seed));
        if (rd_valid === 1'b1) got.push_back(rd_data);
    end
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t got %0h expected %0h", $time, g, e);
        end
    endtask : check
    task automatic add(input logic [31:0] v, input int n, input logic [1:0] w);
        int l;
        l = 1 << w;
        for (int i = n - l; i >= 0; i -= l) begin
            exq.push_back(4'((v >> i) & ((1 << l) - 1)));
            emk.push_back(4'((1 << l) - 1));
        end
    endtask : add
    task automatic run(input logic m, d, s, input logic [1:0] i_w, input logic [5:0] a_b,
        input logic [1:0] a_w, input logic h, input logic [4:0] d_m, input logic [1:0] d_w,
        input logic w, input logic [5:0] n);
        int         ic, k, r;
        logic [3:0] rx[$];
        @(negedge clk);
        {m3, ddr, skip, iw, ab, aw, hm, dm, dw, wr, nb} = {m, d, s, i_w, a_b, a_w, h, d_m, d_w, w, n};
        instr = 8'($random(seed));
        addr = $random(seed);
        mbits = 8'($random(seed));
        rd_base = 8'($random(seed));
        exq.delete();
        emk.delete();
        got.delete();
        sfc_flash_model_inst.rx.delete();
        if (!s) add(instr, 8, i_w);
        add(addr, int'(a_b), a_w);
        if (h) add(mbits, 8, a_w);
        for (k = 0; k < int'(n) && w; k++) begin
            wq.push_back(8'($random(seed)));
            add(wq[k], 8, d_w);
        end
        ic = s ? 0 : 8 >> i_w;
        ddr_fall = 8'(ic + m);
        r = ic + (a_b >> a_w >> d) + (h ? 8 >> a_w >> d : 0) + d_m + m;
        rd_fall = (w || n == 6'h00) ? 8'hFF : 8'(r);
        rd_w = 3'(1 << d_w);
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        for (k = 0; k < 4000 && cmd_ready !== 1'b1; k++) @(negedge clk);
        repeat (4) @(negedge clk);
        check(k < 4000, 1);
        rx = sfc_flash_model_inst.rx;
        if (!w && n > 6'h00) begin
            check(got.size(), n);
            foreach (got[j]) check(got[j], 8'(rd_base + j));
        end
        check(rx.size() >= exq.size(), 1);
        if (w) check(rx.size(), exq.size());
        foreach (exq[j]) if (j < rx.size()) check(rx[j] & emk[j], exq[j]);
    endtask : run
    task automatic stop_test();
        if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
    initial begin
        seed = 39124;
        error_cnt = 0;
        checked = 0;
        nrst = 1'b0;
        cmd_valid = 1'b0;
        last = 4'h0;
        {m3, ddr, skip, iw, ab, aw, hm, dm, dw, wr, nb} = 28'h0;
        {instr, addr, mbits, wr_data, rd_base, ddr_fall} = 72'h0;
        rd_fall = 8'hFF;
        rd_w = 3'h1;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        run(0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 0);
        run(1, 0, 0, 0, 24, 0, 0, 0, 0, 1, 3);
        run(0, 0, 0, 0, 24, 0, 0, 0, 0, 0, 2);
        run(1, 0, 0, 0, 24, 0, 0, 8, 0, 0, 2);
        run(1, 0, 0, 0, 24, 0, 0, 8, 1, 0, 3);
        run(0, 0, 0, 0, 32, 0, 0, 8, 2, 0, 4);
        run(1, 0, 0, 0, 24, 1, 1, 4, 1, 0, 2);
        run(0, 0, 0, 0, 32, 2, 1, 4, 2, 0, 5);
        run(0, 0, 1, 0, 32, 2, 1, 4, 2, 0, 3);
        run(1, 0, 0, 2, 24, 2, 1, 2, 2, 0, 4);
        run(0, 1, 0, 0, 24, 2, 1, 6, 2, 0, 4);
        run(1, 1, 0, 2, 32, 2, 1, 8, 2, 0, 3);
        run(0, 0, 0, 2, 24, 2, 0, 0, 2, 1, 4);
        run(0, 0, 0, 0, 24, 0, 0, 0, 2, 1, 2);
        stop_test();
    end
endmodule : tb
`default_nettype wire
